// [src/cpu_write_buffer_map.svh]
// Constants for the processor write buffer: sizes, limits, resets
// Assumes inclusion by bare name from files under src/
`ifndef CPU_WRITE_BUFFER_MAP_SVH
`define CPU_WRITE_BUFFER_MAP_SVH
`define WB_ENTRIES      4
`define WB_WORDS        8
`define WB_ENT_FULL     3'h4
`define WB_WORD_FULL    4'h8
`define WB_GROUP_LAST   2'h3
`define WB_FILL_LAST    2'h3
`define WB_SWAP_LAST    2'h1
`define WB_SINGLE_LAST  2'h0
`define WB_SWAP_WRITE   2'h1
`define WB_BE_FULL      4'hF
`define WB_WORD_RST     32'h0000_0000
`define WB_BE_RST       4'h0
`define WB_PTR_RST      2'h0
`endif

// [src/cpu_write_buffer_pkg.sv]
// Types shared by the write buffer and its entry store
// Assumes no other package; users write the package name out
package cpu_write_buffer_pkg;
  typedef enum logic [2:0] {
    op_load  = 3'h0,
    op_store = 3'h1,
    op_swap  = 3'h2,
    op_drain = 3'h3,
    op_evict = 3'h4
  } op_t;

  typedef enum logic [1:0] {
    uncached_unbuffered_mode = 2'h0,
    uncached_buffered_mode   = 2'h1,
    write_through_mode       = 2'h2,
    write_back_mode          = 2'h3
  } mode_t;

  typedef enum logic [1:0] {
    st_idle  = 2'h0,
    st_drain = 2'h1,
    st_xfer  = 2'h3,
    st_reply = 2'h2
  } state_t;

  // Word address of word idx counted from base inside its group
  function automatic logic [31:0] beat_addr(input logic [31:0] base,
                                            input logic [1:0]  idx);
    logic [1:0] w;
    w = base[3:2] + idx;
    return {base[31:4], w, 2'h0};
  endfunction
endpackage

// [src/wbuf_if.sv]
// Carrier between the write buffer control and its entry store
// Assumes one owner and one store on the same clock
interface wbuf_if;
  logic        push;
  logic        append;
  logic        more;
  logic        close;
  logic        pop;
  logic [31:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_be;
  logic [2:0]  ent_count;
  logic [3:0]  word_count;
  logic        tail_open;
  logic [31:0] tail_addr;
  logic        empty;
  logic        head_valid;
  logic        head_first;
  logic [31:0] head_addr;
  logic [31:0] head_data;
  logic [3:0]  head_be;

  modport owner (
    output push, append, more, close, pop, wr_addr, wr_data, wr_be,
    input  ent_count, word_count, tail_open, tail_addr, empty,
    input  head_valid, head_first, head_addr, head_data, head_be
  );
  modport store (
    input  push, append, more, close, pop, wr_addr, wr_data, wr_be,
    output ent_count, word_count, tail_open, tail_addr, empty,
    output head_valid, head_first, head_addr, head_data, head_be
  );
endinterface

// [src/wbuf_store.sv]
// Address entries and data slots of the write buffer
// Assumes the owner checks for room before push or append
`include "cpu_write_buffer_map.svh"
module wbuf_store (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Owner side
  wbuf_if.store    wb
);
  logic [31:0] ent_addr [`WB_ENTRIES];
  logic [2:0]  ent_len  [`WB_ENTRIES];
  logic [31:0] slot     [`WB_WORDS];
  logic [3:0]  slot_be  [`WB_WORDS];
  logic [1:0]  eh;
  logic [1:0]  et;
  logic [2:0]  ecnt;
  logic [2:0]  wh;
  logic [2:0]  wt;
  logic [3:0]  wcnt;
  logic [1:0]  hoff;
  logic        open;

  wire [1:0] et_last = et - 2'h1;
  wire       take    = wb.push | wb.append;
  wire [2:0] hoff_n  = {1'b0, hoff} + 3'h1;
  wire       ent_release = wb.pop & (hoff_n == ent_len[eh]);

  // An open group is never issued, so appends never race a release
  assign wb.head_valid = (ecnt != 3'h0) & ~(open & (ecnt == 3'h1));
  assign wb.head_first = hoff == 2'h0;
  assign wb.head_addr  = cpu_write_buffer_pkg::beat_addr(ent_addr[eh],
                                                         hoff);
  assign wb.head_data  = slot[wh];
  assign wb.head_be    = slot_be[wh];
  assign wb.tail_addr  = ent_addr[et_last];
  assign wb.tail_open  = open;
  assign wb.ent_count  = ecnt;
  assign wb.word_count = wcnt;
  assign wb.empty      = ecnt == 3'h0;

  always_ff @(posedge clk) begin
    if (take) begin
      slot[wt]    <= wb.wr_data;
      slot_be[wt] <= wb.wr_be;
    end
    if (wb.push) begin
      ent_addr[et] <= wb.wr_addr;
      ent_len[et]  <= 3'h1;
    end else if (wb.append) begin
      ent_len[et_last] <= ent_len[et_last] + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      eh   <= `WB_PTR_RST;
      et   <= `WB_PTR_RST;
      ecnt <= 3'h0;
      wh   <= 3'h0;
      wt   <= 3'h0;
      wcnt <= 4'h0;
      hoff <= `WB_PTR_RST;
      open <= 1'b0;
    end else begin
      if (wb.push)
        et <= et + 2'h1;
      if (take)
        wt <= wt + 3'h1;
      if (wb.pop)
        wh <= wh + 3'h1;
      ecnt <= ecnt + {2'h0, wb.push} - {2'h0, ent_release};
      wcnt <= wcnt + {3'h0, take} - {3'h0, wb.pop};
      if (ent_release) begin
        eh   <= eh + 2'h1;
        hoff <= 2'h0;
      end else if (wb.pop) begin
        hoff <= hoff_n[1:0];
      end
      if (take)
        open <= wb.more;
      else if (wb.close)
        open <= 1'b0;
    end
  end
endmodule

// [src/cpu_write_buffer.sv]
// Processor write buffer between core, data cache and system bus
// Assumes core, cache and bus slaves share clk; a request is held
// steady until core_done; bus_ack/bus_error are one-cycle answers.
`include "cpu_write_buffer_map.svh"
module cpu_write_buffer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Region attributes and enables
  input  wire logic        region_cacheable,
  input  wire logic        region_bufferable,
  input  wire logic        dcache_enable,
  input  wire logic        protect_enable,
  // Core request
  input  wire logic        req_valid,
  input  wire logic [2:0]  req_kind,
  input  wire logic [31:0] req_addr,
  input  wire logic [31:0] req_wdata,
  input  wire logic [3:0]  req_be,
  input  wire logic        req_more,
  // Core answer
  output logic             core_done,
  output logic             core_abort,
  output logic [31:0]      core_rdata,
  // Data cache lookup
  input  wire logic        cache_hit,
  input  wire logic [31:0] cache_rdata,
  // Data cache update and linefill
  output logic             cache_wr,
  output logic             cache_dirty,
  output logic [31:0]      cache_addr,
  output logic [31:0]      cache_wdata,
  output logic [3:0]       cache_be,
  output logic             fill_valid,
  output logic [31:0]      fill_addr,
  output logic [31:0]      fill_data,
  // System bus master
  output logic             bus_req,
  output logic             bus_write,
  output logic             bus_nonseq,
  output logic [31:0]      bus_addr,
  output logic [31:0]      bus_wdata,
  output logic [3:0]       bus_be,
  input  wire logic        bus_ack,
  input  wire logic        bus_error,
  input  wire logic [31:0] bus_rdata,
  // Status
  output logic             buffer_empty
);
  wbuf_if wb ();

  wbuf_store u_store (
    .clk     (clk),
    .reset_n (reset_n),
    .wb      (wb)
  );

  cpu_write_buffer_pkg::state_t state;
  cpu_write_buffer_pkg::state_t next_state;
  cpu_write_buffer_pkg::op_t    kind;
  cpu_write_buffer_pkg::op_t    op_kind;
  cpu_write_buffer_pkg::mode_t  mode;
  logic [31:0] op_addr;
  logic [31:0] op_data;
  logic [3:0]  op_be;
  logic        op_fill;
  logic        op_abort_ok;
  logic [1:0]  op_last;
  logic [1:0]  beat;
  logic        abort_flag;
  logic        bus_by_fsm;

  wire effective_cacheable = region_cacheable & dcache_enable &
                             protect_enable;
  wire effective_bufferable = region_bufferable & protect_enable;

  assign mode = cpu_write_buffer_pkg::mode_t'({effective_cacheable,
                                               effective_bufferable});
  assign kind = cpu_write_buffer_pkg::op_t'(req_kind);

  wire is_uncached_unbuffered_mode  = mode == cpu_write_buffer_pkg::uncached_unbuffered_mode;
  wire is_ncb   = mode == cpu_write_buffer_pkg::uncached_buffered_mode;
  wire is_wt    = mode == cpu_write_buffer_pkg::write_through_mode;
  wire is_wb    = mode == cpu_write_buffer_pkg::write_back_mode;
  wire is_load  = kind == cpu_write_buffer_pkg::op_load;
  wire is_store = kind == cpu_write_buffer_pkg::op_store;
  wire is_swap  = kind == cpu_write_buffer_pkg::op_swap;
  wire is_drain = kind == cpu_write_buffer_pkg::op_drain;
  wire is_evict = kind == cpu_write_buffer_pkg::op_evict;
  wire known    = is_load | is_store | is_swap | is_drain | is_evict;

  wire take = (state == cpu_write_buffer_pkg::st_idle) & req_valid;

  // append only inside the open 4-word group
  // aligned eviction lands in one group
  wire same_group = req_addr[31:4] == wb.tail_addr[31:4];
  wire can_append = wb.tail_open & same_group & (is_store | is_evict);
  wire group_more = req_more & (req_addr[3:2] != `WB_GROUP_LAST);

  wire wants_buffer = is_evict |
                      (is_store & (is_ncb | is_wt | (is_wb & ~cache_hit)));

  // a full word store, or no free entry for a new group, stalls the core
  wire room_word = wb.word_count != `WB_WORD_FULL;
  wire room_ent  = wb.ent_count != `WB_ENT_FULL;
  wire room      = room_word & (can_append | room_ent);
  wire buf_go    = take & wants_buffer & room;

  wire wb_hit   = take & is_store & is_wb & cache_hit;
  wire load_hit = take & is_load & effective_cacheable & cache_hit;
  // buffered hit also updates the line
  wire upd_go   = wb_hit | (buf_go & is_store & cache_hit);

  // these wait for the buffer to empty
  wire ext_go   = take & (is_drain | is_swap |
                          (is_load & ~load_hit) |
                          (is_store & is_uncached_unbuffered_mode));
  wire bad_go   = take & ~known;

  wire drained  = wb.empty & ~bus_req;
  wire fsm_ack  = bus_req & bus_ack & bus_by_fsm;
  wire eng_ack  = bus_req & bus_ack & ~bus_by_fsm;
  wire fsm_go   = (state == cpu_write_buffer_pkg::st_xfer) & ~bus_req;
  wire eng_go   = ~bus_req & wb.head_valid &
                  (state != cpu_write_buffer_pkg::st_xfer);

  wire op_swap  = op_kind == cpu_write_buffer_pkg::op_swap;
  wire beat_wr  = (op_kind == cpu_write_buffer_pkg::op_store) |
                  (op_swap & (beat == `WB_SWAP_WRITE));
  wire err_now  = fsm_ack & bus_error & op_abort_ok;
  // Aborted swap read skips its write half
  wire last_ack = fsm_ack & ((beat == op_last) | (op_swap & bus_error));
  wire [31:0] beat_adr = op_fill ?
    cpu_write_buffer_pkg::beat_addr({op_addr[31:4], 4'h0}, beat) :
    op_addr;
  wire want_word = ~op_fill | (beat == op_addr[3:2]);

  // a store or eviction into the open group shares its entry
  assign wb.push    = buf_go & ~can_append;
  assign wb.append  = buf_go & can_append;
  assign wb.more    = group_more;
  assign wb.close   = take & ~can_append;
  assign wb.pop     = eng_ack;
  assign wb.wr_addr = req_addr;
  assign wb.wr_data = req_wdata;
  assign wb.wr_be   = req_be;

  always_comb begin
    next_state = state;
    unique case (state)
      cpu_write_buffer_pkg::st_idle: begin
        if (ext_go)
          next_state = cpu_write_buffer_pkg::st_drain;
        else if (buf_go | wb_hit | load_hit | bad_go)
          next_state = cpu_write_buffer_pkg::st_reply;
      end
      // hold until every entry is out
      cpu_write_buffer_pkg::st_drain: begin
        if (drained & (op_kind == cpu_write_buffer_pkg::op_drain))
          next_state = cpu_write_buffer_pkg::st_reply;
        else if (drained)
          next_state = cpu_write_buffer_pkg::st_xfer;
      end
      cpu_write_buffer_pkg::st_xfer: begin
        if (last_ack)
          next_state = cpu_write_buffer_pkg::st_reply;
      end
      cpu_write_buffer_pkg::st_reply: begin
        next_state = cpu_write_buffer_pkg::st_idle;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state       <= cpu_write_buffer_pkg::st_idle;
      op_kind     <= cpu_write_buffer_pkg::op_load;
      op_addr     <= `WB_WORD_RST;
      op_data     <= `WB_WORD_RST;
      op_be       <= `WB_BE_RST;
      op_fill     <= 1'b0;
      op_abort_ok <= 1'b0;
      op_last     <= `WB_SINGLE_LAST;
      beat        <= `WB_PTR_RST;
      abort_flag  <= 1'b0;
    end else begin
      state <= next_state;
      if (ext_go) begin
        op_kind <= kind;
        op_addr <= req_addr;
        op_data <= req_wdata;
        op_be   <= req_be;
        op_fill <= is_load & effective_cacheable;
        op_abort_ok <= is_swap | (is_load & ~effective_cacheable) |
                       (is_store & is_uncached_unbuffered_mode);
        if (is_load & effective_cacheable)
          op_last <= `WB_FILL_LAST;
        else if (is_swap)
          op_last <= `WB_SWAP_LAST;
        else
          op_last <= `WB_SINGLE_LAST;
        beat       <= `WB_PTR_RST;
        abort_flag <= 1'b0;
      end else begin
        if (fsm_ack)
          beat <= beat + 2'h1;
        if (err_now)
          abort_flag <= 1'b1;
      end
    end
  end

  // Bus request stays up until acknowledged
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bus_req    <= 1'b0;
      bus_by_fsm <= 1'b0;
      bus_write  <= 1'b0;
      bus_nonseq <= 1'b0;
      bus_addr   <= `WB_WORD_RST;
      bus_wdata  <= `WB_WORD_RST;
      bus_be     <= `WB_BE_RST;
    end else if (bus_req) begin
      if (bus_ack)
        bus_req <= 1'b0;
    end else if (fsm_go) begin
      bus_req    <= 1'b1;
      bus_by_fsm <= 1'b1;
      bus_write  <= beat_wr;
      bus_nonseq <= ~op_fill | (beat == 2'h0);
      bus_addr   <= beat_adr;
      bus_wdata  <= op_data;
      bus_be     <= op_fill ? `WB_BE_FULL : op_be;
    end else if (eng_go) begin
      bus_req    <= 1'b1;
      bus_by_fsm <= 1'b0;
      bus_write  <= 1'b1;
      bus_nonseq <= wb.head_first;
      bus_addr   <= wb.head_addr;
      bus_wdata  <= wb.head_data;
      bus_be     <= wb.head_be;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      core_done    <= 1'b0;
      core_abort   <= 1'b0;
      core_rdata   <= `WB_WORD_RST;
      fill_valid   <= 1'b0;
      fill_addr    <= `WB_WORD_RST;
      fill_data    <= `WB_WORD_RST;
      buffer_empty <= 1'b1;
    end else begin
      core_done  <= next_state == cpu_write_buffer_pkg::st_reply;
      core_abort <= (next_state == cpu_write_buffer_pkg::st_reply) &
                    (state == cpu_write_buffer_pkg::st_xfer) &
                    (abort_flag | err_now);
      if (load_hit)
        core_rdata <= cache_rdata;
      else if (fsm_ack & ~beat_wr & want_word)
        core_rdata <= bus_rdata;
      // fill words pass to the cache
      fill_valid   <= fsm_ack & op_fill;
      fill_addr    <= bus_addr;
      fill_data    <= bus_rdata;
      buffer_empty <= wb.empty;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cache_wr    <= 1'b0;
      cache_dirty <= 1'b0;
      cache_addr  <= `WB_WORD_RST;
      cache_wdata <= `WB_WORD_RST;
      cache_be    <= `WB_BE_RST;
    end else begin
      cache_wr    <= upd_go;
      cache_dirty <= wb_hit;
      if (upd_go) begin
        cache_addr  <= req_addr;
        cache_wdata <= req_wdata;
        cache_be    <= req_be;
      end
    end
  end
endmodule

// [verification/cpu_write_buffer_assertions.sv]
// Concurrent checks on the write buffer top-level ports
// Assumes it is bound into cpu_write_buffer; one clock domain
module cpu_write_buffer_assertions (
  // Clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // Attributes and enables
  input wire logic        region_cacheable,
  input wire logic        region_bufferable,
  input wire logic        dcache_enable,
  input wire logic        protect_enable,
  // Core side
  input wire logic        req_valid,
  input wire logic [2:0]  req_kind,
  input wire logic        cache_hit,
  input wire logic [31:0] cache_rdata,
  input wire logic        core_done,
  input wire logic        core_abort,
  input wire logic [31:0] core_rdata,
  input wire logic        cache_wr,
  input wire logic        cache_dirty,
  // Bus side
  input wire logic        bus_req,
  input wire logic        bus_write,
  input wire logic        bus_nonseq,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic [3:0]  bus_be,
  input wire logic        bus_ack,
  input wire logic        bus_error,
  input wire logic        buffer_empty
);
  localparam logic [2:0] k_ld = cpu_write_buffer_pkg::op_load;
  localparam logic [2:0] k_st = cpu_write_buffer_pkg::op_store;
  localparam logic [2:0] k_sw = cpu_write_buffer_pkg::op_swap;
  wire logic eff_c = region_cacheable & dcache_enable & protect_enable;
  wire logic eff_b = region_bufferable & protect_enable;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Request seen for the first time, so the design is idle
  sequence s_new_req;
    $rose(req_valid);
  endsequence
  sequence s_unbuf_done;
    core_done && !eff_c && !eff_b && req_kind == k_st;
  endsequence

  a_reset_flush: assert property (
    $rose(reset_n) |-> buffer_empty && !bus_req && !core_done)
    else $error("buffer not flushed by reset");
  a_beat_hold: assert property (
    bus_req && !bus_ack |=> bus_req && $stable(bus_addr)
      && $stable(bus_wdata) && $stable(bus_write))
    else $error("bus beat changed before ack");
  a_beat_gap: assert property (
    bus_req && bus_ack |=> !bus_req)
    else $error("no idle cycle after bus ack");
  a_unbuf_wait: assert property (
    s_unbuf_done |-> $past(bus_ack && bus_write)
      && core_abort == $past(bus_error))
    else $error("unbuffered store not tied to bus beat");
  a_buf_quiet: assert property (
    core_done && eff_b && req_kind == k_st |-> !core_abort)
    else $error("buffered store reported abort");
  a_cached_quiet: assert property (
    core_done && eff_c && req_kind != k_sw |-> !core_abort)
    else $error("cacheable access reported abort");
  a_quick_accept: assert property (
    s_new_req ##0 (req_kind == k_st && (eff_c || eff_b) && buffer_empty)
      |-> ##1 core_done)
    else $error("store with room not accepted in one cycle");
  a_hit_read: assert property (
    s_new_req ##0 (req_kind == k_ld && cache_hit && eff_c)
      |-> ##1 (core_done && core_rdata == $past(cache_rdata)))
    else $error("cache read hit not returned next cycle");
  a_dirty_wb: assert property (
    cache_dirty |-> cache_wr && eff_c && eff_b)
    else $error("dirty mark outside write-back hit");
  a_subword_ns: assert property (
    bus_req && bus_write && bus_be != 4'hF |-> bus_nonseq)
    else $error("partial write issued sequential");
endmodule

bind cpu_write_buffer cpu_write_buffer_assertions u_chk (
  .clk, .reset_n, .region_cacheable, .region_bufferable,
  .dcache_enable, .protect_enable, .req_valid, .req_kind, .cache_hit,
  .cache_rdata, .core_done, .core_abort, .core_rdata, .cache_wr,
  .cache_dirty, .bus_req, .bus_write, .bus_nonseq, .bus_addr,
  .bus_wdata, .bus_be, .bus_ack, .bus_error, .buffer_empty
);

// [verification/bus_slave_model.sv]
// Behavioural system bus slave answering the write buffer
// Assumes the bench sets the wait count and the error level
module bus_slave_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Master side
  input  wire logic        bus_req,
  input  wire logic [31:0] bus_addr,
  // Bench controls
  input  wire logic [7:0]  wait_cycles,
  input  wire logic        fail_beats,
  // Slave answer
  output logic             bus_ack = 1'h0,
  output logic             bus_error = 1'h0,
  output logic [31:0]      bus_rdata = 32'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] waited;

  always @(posedge clk) begin
    bus_ack   <= 1'h0;
    bus_error <= 1'h0;
    // Idle data toggles so a stale word never passes for an answer
    bus_rdata <= ~bus_rdata;
    if (!reset_n) begin
      waited <= 8'h0;
    end else if (bus_req && !bus_ack && waited == wait_cycles) begin
      bus_ack   <= 1'h1;
      bus_error <= fail_beats;
      bus_rdata <= bus_addr ^ 32'h5A5A_0000;
      waited    <= 8'h0;
    end else if (bus_req && !bus_ack) begin
      waited <= waited + 8'h1;
    end
  end
endmodule

// [verification/tb_top.sv]
// Self-checking bench for the processor write buffer
// Assumes the slave model and the bound checker are compiled first
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0]  k_ld = cpu_write_buffer_pkg::op_load;
  localparam logic [2:0]  k_st = cpu_write_buffer_pkg::op_store;
  localparam logic [2:0]  k_sw = cpu_write_buffer_pkg::op_swap;
  localparam logic [2:0]  k_dr = cpu_write_buffer_pkg::op_drain;
  localparam logic [2:0]  k_ev = cpu_write_buffer_pkg::op_evict;
  localparam logic [31:0] pat  = 32'h5A5A_0000;
  logic        clk, reset_n, req_valid, req_more, cache_hit, fail_beats;
  logic        region_cacheable, region_bufferable;
  logic        dcache_enable, protect_enable, ab;
  logic        core_done, core_abort, cache_wr, cache_dirty, fill_valid;
  logic        bus_req, bus_write, bus_nonseq, bus_ack, bus_error;
  logic        buffer_empty;
  logic [2:0]  req_kind;
  logic [3:0]  req_be;
  logic [7:0]  wait_cycles;
  logic [31:0] req_addr, req_wdata, cache_rdata, core_rdata, rd, a;
  logic [31:0] bus_addr, bus_rdata;
  logic [31:0] log_addr[$];
  logic        log_ns[$];
  int          errors, checks_done, lat, n_cw, n_dirty, n_fill, n_rd;
  int          i, n0, n1;

  cpu_write_buffer DUT (
    .clk, .reset_n, .region_cacheable, .region_bufferable,
    .dcache_enable, .protect_enable, .req_valid, .req_kind, .req_addr,
    .req_wdata, .req_be, .req_more, .core_done, .core_abort,
    .core_rdata, .cache_hit, .cache_rdata, .cache_wr, .cache_dirty,
    .cache_addr(), .cache_wdata(), .cache_be(), .fill_valid,
    .fill_addr(), .fill_data(), .bus_req, .bus_write, .bus_nonseq,
    .bus_addr, .bus_wdata(), .bus_be(), .bus_ack, .bus_error,
    .bus_rdata, .buffer_empty
  );
  bus_slave_model slave (
    .clk, .reset_n, .bus_req, .bus_addr, .wait_cycles, .fail_beats,
    .bus_ack, .bus_error, .bus_rdata
  );

  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // Mid-cycle sampling keeps the logs clear of edge races
  always @(negedge clk) begin
    if (bus_req === 1'h1 && bus_ack === 1'h1 && bus_write === 1'h1) begin
      log_addr.push_back(bus_addr);
      log_ns.push_back(bus_nonseq);
    end
    n_rd    += (bus_req === 1'h1 && bus_ack === 1'h1 && bus_write === 1'h0);
    n_cw    += (cache_wr === 1'h1);
    n_dirty += (cache_dirty === 1'h1);
    n_fill  += (fill_valid === 1'h1);
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Latency counts edges from presentation, so quick accept reads 2
  task automatic acc(input logic [2:0] k, input logic [31:0] ad, d,
                     input logic [3:0] be, input logic more);
    @(posedge clk);
    req_valid <= 1'h1;
    req_kind  <= k;
    req_addr  <= ad;
    req_wdata <= d;
    req_be    <= be;
    req_more  <= more;
    lat = 0;
    do begin
      @(posedge clk);
      lat++;
    end while (core_done !== 1'h1 && lat < 3000);
    if (lat >= 3000)
      chk("core_done", 32'h1, 32'h0);
    ab = core_abort;
    rd = core_rdata;
    req_valid <= 1'h0;
  endtask

  task automatic mode(input logic c, b, d, p);
    @(posedge clk);
    region_cacheable  <= c;
    region_bufferable <= b;
    dcache_enable     <= d;
    protect_enable    <= p;
  endtask

  function automatic logic [31:0] stm_addr(input int j);
    if (j > 10)
      return 32'h300;
    return ((j < 6) ? 32'h10C : 32'h1F4) + 32'(4 * j);
  endfunction

  initial begin
    #300000;
    chk("watchdog", 32'h1, 32'h0);
    test_done();
  end

  initial begin
    {reset_n, req_valid, req_more, cache_hit, fail_beats} = 5'h0;
    {region_cacheable, region_bufferable} = 2'h0;
    {dcache_enable, protect_enable} = 2'h0;
    {req_kind, req_be, wait_cycles} = 15'h0;
    {req_addr, req_wdata, cache_rdata} = 96'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    @(posedge clk);
    chk("empty", 32'h1, 32'(buffer_empty));
    mode(1'h0, 1'h0, 1'h1, 1'h1);
    wait_cycles <= 8'h2;
    fail_beats <= 1'h1;
    acc(k_st, 32'h100, 32'h11, 4'hF, 1'h0);
    chk("store abort", 32'h1, 32'(ab));
    chk("bus writes", 32'h1, 32'(log_addr.size()));
    acc(k_ld, 32'h104, 32'h0, 4'hF, 1'h0);
    chk("load abort", 32'h1, 32'(ab));
    fail_beats <= 1'h0;
    cache_hit <= 1'h1;
    acc(k_ld, 32'h108, 32'h0, 4'hF, 1'h0);
    chk("load data", 32'h108 ^ pat, rd);
    mode(1'h0, 1'h1, 1'h1, 1'h0);
    fail_beats <= 1'h1;
    acc(k_st, 32'h120, 32'h22, 4'hF, 1'h0);
    chk("unprotected", 32'h1, 32'(ab));
    $display("test unbuffered finished");
    mode(1'h0, 1'h1, 1'h0, 1'h1);
    wait_cycles <= 8'h8;
    acc(k_st, 32'h130, 32'h33, 4'hF, 1'h0);
    chk("accept", 32'h2, 32'(lat));
    chk("store abort", 32'h0, 32'(ab));
    acc(k_ld, 32'h134, 32'h0, 4'hF, 1'h0);
    chk("load abort", 32'h1, 32'(ab));
    chk("drained", 32'h130, log_addr[$]);
    acc(k_sw, 32'h138, 32'h0, 4'hF, 1'h0);
    chk("swap abort", 32'h1, 32'(ab));
    fail_beats <= 1'h0;
    n0 = n_cw;
    acc(k_st, 32'h13C, 32'h44, 4'hF, 1'h0);
    chk("hit update", 32'(n0 + 1), 32'(n_cw));
    acc(k_dr, 32'h0, 32'h0, 4'hF, 1'h0);
    chk("hit queued", 32'h13C, log_addr[$]);
    @(posedge clk);
    chk("empty", 32'h1, 32'(buffer_empty));
    $display("test buffered finished");
    cache_hit <= 1'h0;
    wait_cycles <= 8'h28;
    log_addr.delete();
    log_ns.delete();
    for (i = 0; i < 11; i++) begin
      acc(k_st, stm_addr(i), 32'(i), 4'hF, i != 5 && i != 10);
      // Word 7 waits for a free entry; words 9 and 10 wait for a slot: eight words already held
      if (i == 7 || i > 8)
        chk("stall", 32'h1, 32'(lat > 8));
      else
        chk("accept", 32'h2, 32'(lat));
    end
    acc(k_st, 32'h300, 32'h0, 4'h3, 1'h0);
    acc(k_st, 32'h300, 32'h0, 4'hC, 1'h0);
    acc(k_dr, 32'h0, 32'h0, 4'hF, 1'h0);
    chk("beats", 32'hD, 32'(log_addr.size()));
    for (i = 0; i < 13; i++) begin
      a = stm_addr(i);
      chk("order", a, log_addr[i]);
      chk("nonseq", 32'(a[3:2] == 2'h0 || i == 0 || i == 6),
          32'(log_ns[i]));
    end
    $display("test store multiple finished");
    mode(1'h1, 1'h0, 1'h1, 1'h1);
    wait_cycles <= 8'h2;
    fail_beats <= 1'h1;
    cache_hit <= 1'h1;
    cache_rdata <= 32'hCAFE_0001;
    n0 = n_dirty;
    n1 = n_cw;
    acc(k_st, 32'h400, 32'h55, 4'hF, 1'h0);
    chk("clean hit", 32'(n0), 32'(n_dirty));
    chk("hit update", 32'(n1 + 1), 32'(n_cw));
    chk("store abort", 32'h0, 32'(ab));
    n0 = n_rd;
    acc(k_ld, 32'h404, 32'h0, 4'hF, 1'h0);
    chk("hit data", 32'hCAFE_0001, rd);
    chk("hit reads", 32'(n0), 32'(n_rd));
    cache_hit <= 1'h0;
    n0 = n_fill;
    acc(k_ld, 32'h410, 32'h0, 4'hF, 1'h0);
    chk("fill words", 32'(n0 + 4), 32'(n_fill));
    chk("fill abort", 32'h0, 32'(ab));
    chk("through", 32'h400, log_addr[$]);
    mode(1'h1, 1'h1, 1'h1, 1'h1);
    cache_hit <= 1'h1;
    n0 = n_dirty;
    n1 = log_addr.size();
    acc(k_st, 32'h500, 32'h66, 4'hF, 1'h0);
    chk("dirty", 32'(n0 + 1), 32'(n_dirty));
    cache_hit <= 1'h0;
    n0 = n_cw;
    acc(k_st, 32'h504, 32'h77, 4'hF, 1'h0);
    chk("no allocate", 32'(n0), 32'(n_cw));
    for (i = 0; i < 4; i++) begin
      acc(k_ev, 32'h600 + 32'(4 * i), 32'(i), 4'hF, i < 3);
      chk("evict abort", 32'h0, 32'(ab));
    end
    acc(k_dr, 32'h0, 32'h0, 4'hF, 1'h0);
    chk("wb beats", 32'(n1 + 5), 32'(log_addr.size()));
    chk("miss queued", 32'h504, log_addr[n1]);
    chk("line first", 32'h1, 32'(log_ns[n1 + 1]));
    chk("line rest", 32'h0, 32'(log_ns[n1 + 2] | log_ns[n1 + 3]
        | log_ns[n1 + 4]));
    $display("test cached modes finished");
    mode(1'h1, 1'h1, 1'h0, 1'h1);
    cache_hit <= 1'h1;
    fail_beats <= 1'h0;
    acc(k_ld, 32'h700, 32'h0, 4'hF, 1'h0);
    chk("cache off", 32'h700 ^ pat, rd);
    mode(1'h0, 1'h1, 1'h1, 1'h1);
    wait_cycles <= 8'h28;
    n1 = log_addr.size();
    acc(k_st, 32'h800, 32'h88, 4'hF, 1'h0);
    reset_n <= 1'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    repeat (60) @(posedge clk);
    chk("flushed", 32'(n1), 32'(log_addr.size()));
    chk("empty", 32'h1, 32'(buffer_empty));
    $display("test reset finished");
    test_done();
  end
endmodule
